//--- verilog/ldcp_ctrl.sv
// controller driving a low-latency eight-bank dram through its pins
// Behaviour
// (RL1) mode set with split bit one makes addresses come in two edges; the code selects this by control bit LDCP_CTRL_MUXED instead
// (RL2) bank goes with command and first address half, same edge
// (RL3) refresh needs no second address edge, may repeat every cycle
// (RL4) loop bit defaults low, disabled; high enables the loop
// (RL5) after loop enable wait 1024 cycles before any read
// (RL6) on clock change reset loop: mode set low, recovery, mode set high
// (RL7) impedance bit high: device samples precision resistor transparently
// (RL8) impedance bit low: internal nominal 50 ohm, still adjusted
// (RL9) termination bit one terminates data and mask lines only
// (RL10) termination drops while device drives read data
// (RL11) write data on both edges, latency is read latency plus one
// (RL12) at least one idle cycle between write and following read
// (RL13) data elements with mask high are not written
// (RL14) read data edge-aligned with read strobe after read latency
// (RL15) valid flag rises half cycle before first read element
// (RL16) valid flag falls on last element, then data lines float
// (RL17) read strobes run free; back-to-back reads stream continuously
// (RL18) each read strobe serves its own half of the data lines; the code captures all data lines on read strobe 0 only
// (RL19) extra idle cycles may separate read burst and write
// (RL20) refresh names a bank only; row comes from device counter
// (RL21) refresh to command on same bank waits row cycle time
// (RL22) refresh eight banks every 3.9 us
// (RL23) mode set drives eighteen address bits into mode register
// (RL24) three low mode bits select latency configuration
// (RL25) per-bank timer blocks commands until row cycle elapsed
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "ldcp_regs.svh"
module ldcp_ctrl #(
   parameter int DW = 36,
   parameter int AW = 21,
   parameter int REF_INT = `LDCP_REF_INT_CYC
)(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic mem_ck_o,
   output logic mem_cs_n_o,
   output logic mem_we_n_o,
   output logic mem_ref_n_o,
   output logic [AW-1:0] mem_addr_o,
   output logic [2:0] mem_bank_o,
   output logic write_data_clock_o,
   output logic [DW-1:0] mem_dq_o,
   output logic mem_dq_oe_n_o,
   output logic [1:0] write_mask_o,
   input wire logic [DW-1:0] mem_dq_i,
   input wire logic [1:0] read_strobe_clock_i,
   input wire logic read_valid_flag_i
);
   ldcp_pkg::ldcp_state_t st_q;
   logic ck_q;
   logic [1:0] ctrl_q;
   logic [17:0] mode_q;
   logic [28:0] cmd_q;
   logic [31:0] wdata_q;
   logic [DW-1:0] rdata_q;
   logic rvalid_q;
   logic busy_q;
   logic [10:0] lock_q;
   logic [5:0] cnt_q;
   logic rd_ack_q;
   logic [3:0] wait_q;
   logic [15:0] ref_tmr_q;
   logic [2:0] ref_bank_q;
   logic ref_pend_q;
   logic [3:0] bank_tmr_q [0:7];
   logic [1:0] vld_s_q;
   logic [1:0] qk_s_q;
   logic qk_d_q;
   logic [3:0] rl;
   logic [3:0] row_cycle_time;
   logic [3:0] bl;
   logic ph;
   logic [1:0] op;
   logic [2:0] bank;
   logic bank_ok;
   logic cmd_go;
   logic strobe_rise;
   logic ref_go;
   // latency configuration table, three low mode bits
   always_comb
   begin
      case (mode_q[`LDCP_MODE_LAT_HI:`LDCP_MODE_LAT_LO]) // RL24
         3'h1: rl = 4'h6;
         3'h2: rl = 4'h8;
         3'h3: rl = 4'h3;
         3'h4: rl = 4'h5;
         default: rl = 4'h4;
      endcase
      row_cycle_time = rl;
      case (mode_q[`LDCP_MODE_BL_HI:`LDCP_MODE_BL_LO])
         2'h1: bl = 4'h4;
         2'h2: bl = 4'h8;
         default: bl = 4'h2;
      endcase
   end
   assign op = cmd_q[`LDCP_CMD_OP_HI:`LDCP_CMD_OP_LO];
   assign bank = cmd_q[`LDCP_CMD_BANK_HI:`LDCP_CMD_BANK_LO];
   assign bank_ok = (bank_tmr_q[bank] == 4'h0); // RL25
   // reads blocked until the loop has locked
   assign cmd_go = (st_q == ldcp_pkg::LDCP_ISSUE) && ph && bank_ok &&
      (wait_q == 4'h0) &&
      !(op == ldcp_pkg::LDCP_OP_READ && lock_q != 11'h000); // RL5
   assign ref_go = (st_q == ldcp_pkg::LDCP_IDLE) && ref_pend_q && ph &&
      (bank_tmr_q[ref_bank_q] == 4'h0); // RL21
   // memory clock is half the system clock; commands change on ck fall
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         ck_q <= 1'b0;
      else
         ck_q <= ~ck_q;
   end
   assign ph = ck_q;
   assign mem_ck_o = ck_q;
   assign write_data_clock_o = ck_q; // RL11
   // reads take one wait state so the registered data stands when released
   assign avs_waitrequest_o = avs_read_i && !rd_ack_q;
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         rd_ack_q <= 1'b0;
      else
         rd_ack_q <= avs_waitrequest_o;
   end
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         avs_readdata_o <= 32'h00000000;
      else if (avs_waitrequest_o)
      begin
         if (avs_address_i == `LDCP_CTRL_ADDR)
            avs_readdata_o <= {30'h0, ctrl_q};
         else if (avs_address_i == `LDCP_MODE_ADDR)
            avs_readdata_o <= {14'h0, mode_q};
         else if (avs_address_i == `LDCP_CMD_ADDR)
            avs_readdata_o <= {3'h0, cmd_q};
         else if (avs_address_i == `LDCP_WDATA_ADDR)
            avs_readdata_o <= wdata_q;
         else if (avs_address_i == `LDCP_RDATA_ADDR)
            avs_readdata_o <= rdata_q[31:0];
         else if (avs_address_i == `LDCP_STATUS_ADDR)
            avs_readdata_o <= {29'h0, rvalid_q, lock_q == 11'h000, busy_q};
         else
            avs_readdata_o <= 32'h00000000;
      end
   end
   // software registers; mode and loop bit default low
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_q <= 2'h0;
         mode_q <= `LDCP_MODE_RESET; // RL4
         wdata_q <= 32'h00000000;
      end
      else if (avs_write_i)
      begin
         if (avs_address_i == `LDCP_CTRL_ADDR)
            ctrl_q <= avs_writedata_i[1:0];
         else if (avs_address_i == `LDCP_MODE_ADDR && !busy_q)
            mode_q <= avs_writedata_i[17:0];
         else if (avs_address_i == `LDCP_WDATA_ADDR)
            wdata_q <= avs_writedata_i;
      end
   end
   // command register write launches a command; ignored while busy
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         cmd_q <= 29'h0;
         busy_q <= 1'b0;
      end
      else if (avs_write_i && avs_address_i == `LDCP_CMD_ADDR && !busy_q)
      begin
         cmd_q <= avs_writedata_i[28:0];
         busy_q <= 1'b1;
      end
      else if (st_q == ldcp_pkg::LDCP_GAP && wait_q == 4'h0)
         busy_q <= 1'b0;
   end
   // loop lock counter restarts whenever a mode set raises the loop bit
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         lock_q <= 11'h7FF;
      else if (cmd_go && op == ldcp_pkg::LDCP_OP_MODE)
         lock_q <= cmd_q[`LDCP_CMD_ADDR_LO + `LDCP_MODE_LOOP] ? // RL6
            11'h400 : 11'h7FF;
      else if (ph && lock_q != 11'h000 && lock_q != 11'h7FF)
         lock_q <= lock_q - 11'h001; // RL5
   end
   // refresh timer; eight banks posted each interval
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         ref_tmr_q <= 16'h0000;
         ref_bank_q <= 3'h0;
         ref_pend_q <= 1'b0;
      end
      else
      begin
         if (ref_tmr_q == 16'h0000 && ctrl_q[`LDCP_CTRL_REFEN])
         begin
            ref_tmr_q <= 16'(REF_INT - 1);
            ref_pend_q <= 1'b1; // RL22
         end
         else if (ref_tmr_q != 16'h0000)
            ref_tmr_q <= ref_tmr_q - 16'h0001;
         if (ref_go)
         begin
            ref_bank_q <= ref_bank_q + 3'h1;
            if (ref_bank_q == 3'h7)
               ref_pend_q <= 1'b0;
         end
      end
   end
   // per-bank row cycle timers, counted in memory clocks
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_bank
         always_ff @(posedge ref_clk_i)
         begin
            if (!rst_n_i)
               bank_tmr_q[g] <= 4'h0;
            else if ((cmd_go && bank == 3'(g)) ||
               (ref_go && ref_bank_q == 3'(g)))
               bank_tmr_q[g] <= row_cycle_time; // RL25
            else if (ph && bank_tmr_q[g] != 4'h0)
               bank_tmr_q[g] <= bank_tmr_q[g] - 4'h1;
         end
      end
   endgenerate
   // command sequencer
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= ldcp_pkg::LDCP_IDLE;
         cnt_q <= 6'h00;
         wait_q <= 4'h0;
      end
      else
      begin
         if (ph && wait_q != 4'h0 && st_q != ldcp_pkg::LDCP_ISSUE)
            wait_q <= wait_q - 4'h1;
         case (st_q)
            ldcp_pkg::LDCP_IDLE:
               if (busy_q && !ref_go && !ref_pend_q)
                  st_q <= ldcp_pkg::LDCP_ISSUE;
            ldcp_pkg::LDCP_ISSUE:
               if (cmd_go)
               begin
                  cnt_q <= 6'h00;
                  if (ctrl_q[`LDCP_CTRL_MUXED] &&
                     op != ldcp_pkg::LDCP_OP_REFRESH) // RL3
                     st_q <= ldcp_pkg::LDCP_SECOND; // RL1
                  else if (op == ldcp_pkg::LDCP_OP_WRITE)
                     st_q <= ldcp_pkg::LDCP_WDATA;
                  else if (op == ldcp_pkg::LDCP_OP_READ)
                     st_q <= ldcp_pkg::LDCP_RWAIT;
                  else
                  begin
                     wait_q <= (op == ldcp_pkg::LDCP_OP_MODE) ?
                        4'(`LDCP_MRSC_CYCLES) : 4'h0; // RL6
                     st_q <= ldcp_pkg::LDCP_GAP;
                  end
               end
            ldcp_pkg::LDCP_SECOND:
               if (ph)
                  st_q <= (op == ldcp_pkg::LDCP_OP_WRITE) ?
                     ldcp_pkg::LDCP_WDATA :
                     (op == ldcp_pkg::LDCP_OP_READ) ?
                     ldcp_pkg::LDCP_RWAIT : ldcp_pkg::LDCP_GAP;
            ldcp_pkg::LDCP_WDATA:
            begin
               cnt_q <= cnt_q + 6'h01;
               // latency plus one, then burst; wide enough for latency 8
               if (cnt_q == 6'((rl + 4'h1) * 2 + bl - 4'h1)) // RL11
               begin
                  wait_q <= 4'h2; // RL12
                  st_q <= ldcp_pkg::LDCP_GAP;
               end
            end
            ldcp_pkg::LDCP_RWAIT:
            begin
               cnt_q <= cnt_q + 6'h01;
               if (rvalid_q || cnt_q == 6'h3F)
               begin
                  wait_q <= 4'h1; // RL19
                  st_q <= ldcp_pkg::LDCP_GAP;
               end
            end
            default:
               if (wait_q == 4'h0)
                  st_q <= ldcp_pkg::LDCP_IDLE;
         endcase
      end
   end
   // command pins: split address sends high half on the second edge
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         mem_cs_n_o <= 1'b1;
         mem_we_n_o <= 1'b1;
         mem_ref_n_o <= 1'b1;
         mem_addr_o <= '0;
         mem_bank_o <= 3'h0;
      end
      else if (ref_go)
      begin
         mem_cs_n_o <= 1'b0; // RL20
         mem_we_n_o <= 1'b1;
         mem_ref_n_o <= 1'b0;
         mem_bank_o <= ref_bank_q;
      end
      else if (cmd_go)
      begin
         mem_cs_n_o <= 1'b0;
         mem_we_n_o <= !(op == ldcp_pkg::LDCP_OP_WRITE ||
            op == ldcp_pkg::LDCP_OP_MODE);
         mem_ref_n_o <= !(op == ldcp_pkg::LDCP_OP_MODE ||
            op == ldcp_pkg::LDCP_OP_REFRESH);
         mem_bank_o <= bank; // RL2
         if (op == ldcp_pkg::LDCP_OP_MODE)
            mem_addr_o <= AW'(mode_q); // RL23
         else
            mem_addr_o <= AW'(cmd_q[`LDCP_CMD_ADDR_HI:`LDCP_CMD_ADDR_LO]);
      end
      else if (st_q == ldcp_pkg::LDCP_SECOND && ph)
      begin
         mem_cs_n_o <= 1'b1;
         mem_addr_o <= AW'(cmd_q[`LDCP_CMD_ADDR_HI:`LDCP_CMD_ADDR_LO] >> 11);
      end
      else if (ph)
         mem_cs_n_o <= 1'b1;
   end
   // write data driven while in the data window; mask held at zero
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         mem_dq_o <= '0;
         mem_dq_oe_n_o <= 1'b1;
         write_mask_o <= 2'h0;
      end
      else if (st_q == ldcp_pkg::LDCP_WDATA &&
         cnt_q >= 6'((rl + 4'h1) * 2 - 4'h1))
      begin
         mem_dq_o <= DW'(wdata_q);
         mem_dq_oe_n_o <= 1'b0;
         write_mask_o <= 2'h0; // RL13
      end
      else
         mem_dq_oe_n_o <= 1'b1;
   end
   // synchronise valid flag and strobe; capture on rising strobe edges
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         vld_s_q <= 2'h0;
         qk_s_q <= 2'h0;
         qk_d_q <= 1'b0;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         vld_s_q <= {vld_s_q[0], read_valid_flag_i}; // RL15
         qk_s_q <= {qk_s_q[0], read_strobe_clock_i[0]}; // RL18
         qk_d_q <= qk_s_q[1];
         if (strobe_rise && vld_s_q[1]) // RL14
         begin
            rdata_q <= mem_dq_i;
            rvalid_q <= 1'b1;
         end
         else if (st_q == ldcp_pkg::LDCP_ISSUE)
            rvalid_q <= 1'b0; // RL16
      end
   end
   // data pins are not synchronised: valid in flag window (RL17)
   assign strobe_rise = qk_s_q[1] && !qk_d_q;
endmodule

//--- verilog/ldcp_regs.svh
// register offsets, field positions and timing counts of the memory controller
`ifndef LDCP_REGS_SVH
`define LDCP_REGS_SVH
// avalon word addresses (byte address = 4 * index)
`define LDCP_CTRL_ADDR 4'h0
`define LDCP_MODE_ADDR 4'h1
`define LDCP_CMD_ADDR 4'h2
`define LDCP_WDATA_ADDR 4'h3
`define LDCP_RDATA_ADDR 4'h4
`define LDCP_STATUS_ADDR 4'h5
// control register fields
`define LDCP_CTRL_REFEN 0
`define LDCP_CTRL_MUXED 1
// mode register fields (18-bit opcode)
`define LDCP_MODE_LAT_LO 0
`define LDCP_MODE_LAT_HI 2
`define LDCP_MODE_BL_LO 3
`define LDCP_MODE_BL_HI 4
`define LDCP_MODE_SPLIT 5
`define LDCP_MODE_LOOP 7
`define LDCP_MODE_IMP 8
`define LDCP_MODE_TERM 9
`define LDCP_MODE_RESET 18'h00000
// command register fields
`define LDCP_CMD_OP_LO 0
`define LDCP_CMD_OP_HI 1
`define LDCP_CMD_BANK_LO 2
`define LDCP_CMD_BANK_HI 4
`define LDCP_CMD_ADDR_LO 8
`define LDCP_CMD_ADDR_HI 28
// status bits
`define LDCP_ST_BUSY 0
`define LDCP_ST_LOCKED 1
`define LDCP_ST_RVALID 2
// timing
`define LDCP_CLK_MHZ 100
`define LDCP_LOCK_CYCLES 1024
`define LDCP_MRSC_CYCLES 6
`define LDCP_REF_INT_NS 3900
`define LDCP_REF_INT_CYC ((`LDCP_REF_INT_NS * `LDCP_CLK_MHZ) / 1000)
`endif

//--- verilog/ldcp_pkg.sv
// types shared by the memory controller
package ldcp_pkg;
   typedef enum logic [1:0]
   {
      LDCP_OP_READ = 2'b00,
      LDCP_OP_WRITE = 2'b01,
      LDCP_OP_MODE = 2'b10,
      LDCP_OP_REFRESH = 2'b11
   } ldcp_op_t;
   typedef enum logic [2:0]
   {
      LDCP_IDLE = 3'b000,
      LDCP_ISSUE = 3'b001,
      LDCP_SECOND = 3'b010,
      LDCP_WDATA = 3'b011,
      LDCP_RWAIT = 3'b100,
      LDCP_GAP = 3'b101
   } ldcp_state_t;
endpackage

//--- testbench/ldcp_ctrl_props.sv
// pin-level timing checker of the memory controller
`timescale 1ns/1ps
module ldcp_ctrl_props #(
   parameter int AW = 21,
   parameter int REF_INT = 390
)(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic mem_cs_n_o,
   input wire logic mem_we_n_o,
   input wire logic mem_ref_n_o,
   input wire logic [AW-1:0] mem_addr_o,
   input wire logic [2:0] mem_bank_o,
   input wire logic mem_dq_oe_n_o,
   input wire logic [1:0] write_mask_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic wr, rd, md, rf, seen_q;
   logic [11:0] lock_q;
   logic [15:0] age_q;
   // command decode from the pin levels
   assign wr = !mem_cs_n_o && !mem_we_n_o && mem_ref_n_o;
   assign rd = !mem_cs_n_o && mem_we_n_o && mem_ref_n_o;
   assign md = !mem_cs_n_o && !mem_we_n_o && !mem_ref_n_o;
   assign rf = !mem_cs_n_o && mem_we_n_o && !mem_ref_n_o;
   // cycles since a mode set turned the loop on, saturating
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i || (md && !mem_addr_o[7]))
         lock_q <= 12'h000;
      else if (md || (lock_q != 12'h000 && lock_q != 12'hFFF))
         lock_q <= lock_q + 12'h001;
   end
   // age of the last refresh, armed by the first one
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         seen_q <= 1'b0;
      else if (rf)
         seen_q <= 1'b1;
      if (!rst_n_i || rf)
         age_q <= 16'h0000;
      else if (age_q != 16'hFFFF)
         age_q <= age_q + 16'h0001;
   end
   a_cmd_hold: assert property (
      $fell(mem_cs_n_o) |=> !mem_cs_n_o && $stable(mem_bank_o)
      && $stable({mem_we_n_o, mem_ref_n_o}))
      else $error("command fields moved within a command");
   a_lock_wait: assert property (
      $rose(rd) |-> lock_q >= 12'h7FE)
      else $error("read before the loop had locked");
   a_mode_rcv: assert property (
      $fell(md) |-> mem_cs_n_o [*8])
      else $error("command inside mode set recovery");
   a_wr_rd_gap: assert property (
      $fell(wr) |-> !rd [*2])
      else $error("read right after write");
   a_wr_data: assert property (
      $rose(wr) |-> ##[2:30] !mem_dq_oe_n_o)
      else $error("write data never driven");
   a_dq_release: assert property (
      $fell(mem_dq_oe_n_o) |-> ##[1:8] mem_dq_oe_n_o)
      else $error("data bus held too long");
   a_mask_clear: assert property (
      write_mask_o == 2'h0)
      else $error("write mask raised");
   a_ref_period: assert property (
      seen_q |-> age_q < 16'(4 * REF_INT))
      else $error("refresh interval overrun");
endmodule
bind ldcp_ctrl ldcp_ctrl_props #(.AW(AW), .REF_INT(REF_INT)) i_props (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mem_cs_n_o(mem_cs_n_o),
   .mem_we_n_o(mem_we_n_o), .mem_ref_n_o(mem_ref_n_o),
   .mem_addr_o(mem_addr_o), .mem_bank_o(mem_bank_o),
   .mem_dq_oe_n_o(mem_dq_oe_n_o), .write_mask_o(write_mask_o)
);

//--- testbench/ldcp_mem_model.sv
// behavioural model of the eight-bank memory device
`timescale 1ns/1ps
module ldcp_mem_model (
   input wire logic ref_clk_i,
   input wire logic ck_i,
   input wire logic cs_n_i,
   input wire logic we_n_i,
   input wire logic ref_n_i,
   input wire logic [20:0] addr_i,
   input wire logic [2:0] bank_i,
   input wire logic [35:0] dq_i,
   input wire logic dq_oe_n_i,
   input wire logic [1:0] mask_i,
   output logic [35:0] dq_o,
   output logic [1:0] strobe_o,
   output logic valid_o
);
   logic [17:0] mode_q = 18'h00000;
   logic [35:0] mem [int];
   logic [35:0] rd_q [$];
   logic [35:0] cur_q = 36'h0;
   logic [39:0] pipe_q = 40'h0;
   logic ck_q = 1'b0;
   logic wr_pend = 1'b0;
   int ref_cnt [8] = '{8{0}};
   int lat_tab [8] = '{4, 6, 8, 3, 5, 4, 4, 4};
   int wkey;
   logic imp_ext, term_on;
   int t;
   // commands are taken at rising memory clock edges
   always @(posedge ref_clk_i)
   begin
      ck_q <= ck_i;
      pipe_q <= {pipe_q[38:0], 1'b0};
      if (pipe_q[t-1])
         cur_q <= rd_q.pop_front();
      if (ck_i && !ck_q && !cs_n_i)
      begin
         if (!we_n_i && !ref_n_i)
            mode_q <= addr_i[17:0];
         else if (!ref_n_i)
            ref_cnt[bank_i]++;
         else if (!we_n_i)
         begin
            wkey = {bank_i, addr_i};
            wr_pend = 1'b1;
         end
         else
         begin
            rd_q.push_back(mem.exists({bank_i, addr_i}) ?
               mem[{bank_i, addr_i}] : 36'h0);
            pipe_q[0] <= 1'b1;
         end
      end
      // first driven element is stored unless masked
      if (wr_pend && !dq_oe_n_i)
      begin
         if (mask_i == 2'h0)
            mem[wkey] = dq_i;
         wr_pend = 1'b0;
      end
   end
   // released bus shows the inverse, never a stale value
   assign t = 2 * lat_tab[mode_q[2:0]];
   assign valid_o = pipe_q[t-1] | pipe_q[t];
   assign dq_o = (pipe_q[t] | pipe_q[t+1]) ? cur_q : ~cur_q;
   assign strobe_o = {ck_i, ck_i};
   // impedance source only noted; updates never disturb timing
   assign imp_ext = mode_q[8];
   // data termination drops while read data is driven
   assign term_on = mode_q[9] && !(pipe_q[t] | pipe_q[t+1]);
endmodule

//--- testbench/tb.sv
// self-checking bench of the memory controller with a device model
`timescale 1ns/1ps
`include "ldcp_regs.svh"
`define CHK(a, b) \
   begin \
      comparisons++; \
      if ((a) !== (b)) \
      begin \
         num_errors++; \
         $display("ERROR %0t got %h exp %h", $time, (a), (b)); \
      end \
   end
module tb;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o, q;
   logic avs_waitrequest_o, mem_ck_o, mem_cs_n_o, mem_we_n_o, mem_ref_n_o;
   logic write_data_clock_o, mem_dq_oe_n_o, read_valid_flag_i;
   logic [20:0] mem_addr_o;
   logic [2:0] mem_bank_o;
   logic [35:0] mem_dq_o, mem_dq_i;
   logic [1:0] write_mask_o, read_strobe_clock_i;
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   ldcp_ctrl #(.REF_INT(40)) i_dut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .mem_ck_o(mem_ck_o),
      .mem_cs_n_o(mem_cs_n_o), .mem_we_n_o(mem_we_n_o),
      .mem_ref_n_o(mem_ref_n_o), .mem_addr_o(mem_addr_o),
      .mem_bank_o(mem_bank_o), .write_data_clock_o(write_data_clock_o),
      .mem_dq_o(mem_dq_o), .mem_dq_oe_n_o(mem_dq_oe_n_o),
      .write_mask_o(write_mask_o), .mem_dq_i(mem_dq_i),
      .read_strobe_clock_i(read_strobe_clock_i),
      .read_valid_flag_i(read_valid_flag_i)
   );
   ldcp_mem_model i_mem (
      .ref_clk_i(ref_clk_i), .ck_i(mem_ck_o), .cs_n_i(mem_cs_n_o),
      .we_n_i(mem_we_n_o), .ref_n_i(mem_ref_n_o), .addr_i(mem_addr_o),
      .bank_i(mem_bank_o), .dq_i(mem_dq_o), .dq_oe_n_i(mem_dq_oe_n_o),
      .mask_i(write_mask_o), .dq_o(mem_dq_i),
      .strobe_o(read_strobe_clock_i), .valid_o(read_valid_flag_i)
   );
   initial
   begin
      forever
         #5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
      cyc++;
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      do
         @(posedge ref_clk_i);
      while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   // one register read, data taken as waitrequest drops
   task automatic rd(input logic [3:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      rd(`LDCP_STATUS_ADDR);
      while (q[b] !== v && n < 1200)
      begin
         rd(`LDCP_STATUS_ADDR);
         n++;
      end
      if (q[b] !== v)
         num_errors++;
   endtask
   task automatic cmd(input logic [1:0] op, input logic [2:0] bk,
      input logic [20:0] ad);
      bus(1'b1, `LDCP_CMD_ADDR, {3'h0, ad, 3'h0, bk, op});
      wait_st(0, 1'b0);
   endtask
   task automatic mode_set(input logic [20:0] m);
      bus(1'b1, `LDCP_MODE_ADDR, {11'h0, m});
      cmd(2'h2, 3'h0, m);
   endtask
   task automatic t_mode();
      int c0;
      rd(`LDCP_STATUS_ADDR);
      `CHK(q[1:0], 2'h0)
      c0 = cyc;
      mode_set(21'h00380);
      `CHK(i_mem.mode_q, 18'h00380)
      rd(`LDCP_STATUS_ADDR);
      `CHK(q[1], 1'b0)
      wait_st(1, 1'b1);
      `CHK(cyc - c0 >= 2048, 1'b1)
      $display("t_mode done");
   endtask
   task automatic t_wr_rd();
      logic [31:0] d;
      for (int b = 0; b < 8; b++)
      begin
         d = {28'hC0DE000, b[3:0]};
         bus(1'b1, `LDCP_WDATA_ADDR, d);
         cmd(2'h1, b[2:0], 21'h01234);
         `CHK(i_mem.mem[{b[2:0], 21'h01234}][31:0], d)
         cmd(2'h0, b[2:0], 21'h01234);
         wait_st(2, 1'b1);
         rd(`LDCP_RDATA_ADDR);
         `CHK(q, d)
      end
      $display("t_wr_rd done");
   endtask
   task automatic t_dll();
      mode_set(21'h00300);
      rd(`LDCP_STATUS_ADDR);
      `CHK({q[1], i_mem.mode_q[7]}, 2'h0)
      `CHK({i_mem.imp_ext, i_mem.mode_q[9]}, 2'h3)
      mode_set(21'h00380);
      wait_st(1, 1'b1);
      cmd(2'h0, 3'h5, 21'h01234);
      wait_st(2, 1'b1);
      rd(`LDCP_RDATA_ADDR);
      `CHK(q, 32'hC0DE0005)
      $display("t_dll done");
   endtask
   task automatic t_refresh();
      int n0 [8];
      n0 = i_mem.ref_cnt;
      bus(1'b1, `LDCP_CTRL_ADDR, 32'h1);
      repeat (400) @(posedge ref_clk_i);
      for (int b = 0; b < 8; b++)
         `CHK(i_mem.ref_cnt[b] - n0[b] >= 5, 1'b1)
      cmd(2'h0, 3'h2, 21'h01234);
      wait_st(2, 1'b1);
      rd(`LDCP_RDATA_ADDR);
      `CHK(q, 32'hC0DE0002)
      $display("t_refresh done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_mode();
      t_wr_rd();
      t_dll();
      t_refresh();
      finish_test();
   end
   // cut a hang short
   initial
   begin
      repeat (40000) @(posedge ref_clk_i);
      num_errors++;
      $display("ERROR %0t timeout %h %h", $time, 1'b0, 1'b1);
      finish_test();
   end
endmodule
